/* rtl/bridge_decay_and_fault_control.sv */
/*
  two-bridge decay selection, synchronous rectification and fault gating.
  assumes osc_tick is a single-cycle pulse per master oscillator cycle, all inputs synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_decay_and_fault_control #(
  parameter logic [7:0] FAST_TAB0 = decay_ctrl_pkg::FAST_SEL0,
  parameter logic [7:0] FAST_TAB1 = decay_ctrl_pkg::FAST_SEL1,
  parameter logic [7:0] FAST_TAB2 = decay_ctrl_pkg::FAST_SEL2,
  parameter logic [7:0] FAST_TAB3 = decay_ctrl_pkg::FAST_SEL3
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       osc_tick,
  // configuration
  input  wire logic                       fast_decay_sel_lo,
  input  wire logic                       fast_decay_sel_hi,
  input  wire logic                       sync_rect_disable,
  // faults
  input  wire logic                       over_temp,
  input  wire logic                       gate_regulator_rail_low,
  input  wire logic                       supply_lockout,
  // bridges
  input  wire decay_ctrl_pkg::bridge_in_t br0_in,
  input  wire decay_ctrl_pkg::bridge_in_t br1_in,
  output logic                            translator_home,
  output decay_ctrl_pkg::gates_t          br0_gates,
  output decay_ctrl_pkg::gates_t          br1_gates,
  output logic [1:0]                      fast_active
);

  function automatic logic [7:0] fast_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: fast_count = FAST_TAB0;
      2'b01: fast_count = FAST_TAB1;
      2'b10: fast_count = FAST_TAB2;
      2'b11: fast_count = FAST_TAB3;
    endcase
  endfunction

  // forward drive of one bridge for the given polarity
  function automatic decay_ctrl_pkg::gates_t drive_gates(input logic pol);
    drive_gates = pol ? 4'b1001 : 4'b0110;
  endfunction

  logic [1:0] sel;
  assign sel = {fast_decay_sel_hi, fast_decay_sel_lo};

  // fault and lockout sequencing
  logic lock_ff, nxt_lock, home_ff, nxt_home;
  logic lock_prev_ff, nxt_lock_prev;
  logic gate_ok;
  // the edge copy resets to the idle level so leaving reset is not taken as a release
  always_comb
  begin
    nxt_lock      = supply_lockout;
    nxt_lock_prev = supply_lockout;
    nxt_home      = lock_prev_ff & ~supply_lockout;
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      lock_ff      <= 1'b1;
      lock_prev_ff <= 1'b0;
      home_ff      <= 1'b0;
    end
    else
    begin
      lock_ff      <= nxt_lock;
      lock_prev_ff <= nxt_lock_prev;
      home_ff      <= nxt_home;
    end
  end
  // home pulse precedes re-enable by one cycle since lock_ff still holds
  assign gate_ok = ~lock_ff & ~supply_lockout & ~over_temp & ~gate_regulator_rail_low;

  decay_ctrl_pkg::bridge_in_t bin [2];
  assign bin[0] = br0_in;
  assign bin[1] = br1_in;

  decay_ctrl_pkg::phase_t ph_ff [2], nxt_ph [2];
  logic [7:0] cnt_ff [2], nxt_cnt [2];
  logic [7:0] fcnt_ff [2], nxt_fcnt [2];
  logic [7:0] blank_ff [2], nxt_blank [2];
  logic [7:0] prev_ff [2], nxt_prev [2];
  logic       mixed_ff [2], nxt_mixed [2];
  logic       zero_ff [2], nxt_zero [2];
  decay_ctrl_pkg::gates_t g_ff [2], nxt_g [2];

  for (genvar b = 0; b < 2; b++)
  begin : g_br
    always_comb
    begin
      nxt_ph[b]    = ph_ff[b];
      nxt_cnt[b]   = cnt_ff[b];
      nxt_fcnt[b]  = fcnt_ff[b];
      nxt_blank[b] = blank_ff[b];
      nxt_prev[b]  = prev_ff[b];
      nxt_mixed[b] = mixed_ff[b];
      nxt_zero[b]  = zero_ff[b];
      nxt_g[b]     = '0;
      if (bin[b].step_pulse)
      begin
        nxt_prev[b]  = bin[b].level;
        nxt_mixed[b] = (bin[b].level < prev_ff[b]) && (sel != 2'b00);
      end
      if (bin[b].zero_cur)
        nxt_zero[b] = 1'b1;
      if (osc_tick && blank_ff[b] != 8'h00)
        nxt_blank[b] = blank_ff[b] - 8'h01;
      unique case (ph_ff[b])
        decay_ctrl_pkg::PH_DRIVE:
        begin
          nxt_g[b] = drive_gates(bin[b].pol);
          if (bin[b].trip && blank_ff[b] == 8'h00)
          begin
            nxt_ph[b]   = decay_ctrl_pkg::PH_DEAD;
            nxt_cnt[b]  = decay_ctrl_pkg::OFF_CYCLES;
            nxt_fcnt[b] = mixed_ff[b] ? fast_count(sel) : 8'h00;
            nxt_blank[b] = decay_ctrl_pkg::DEAD_CYCLES;
            nxt_zero[b] = 1'b0;
            nxt_g[b]    = '0;
          end
        end
        decay_ctrl_pkg::PH_DEAD:
        begin
          // all gates low while the complement turns off
          if (osc_tick && blank_ff[b] == 8'h01)
            nxt_ph[b] = (fcnt_ff[b] != 8'h00 && sel != 2'b00) ? decay_ctrl_pkg::PH_FAST
                                                              : decay_ctrl_pkg::PH_SLOW;
        end
        decay_ctrl_pkg::PH_FAST:
        begin
          // reverse drive; rectification keeps the reverse pair on for low loss
          if (!sync_rect_disable && !zero_ff[b])
            nxt_g[b] = drive_gates(~bin[b].pol);
          if (osc_tick)
          begin
            nxt_fcnt[b] = fcnt_ff[b] - 8'h01;
            nxt_cnt[b]  = cnt_ff[b] - 8'h01;
          end
          if (osc_tick && cnt_ff[b] == 8'h01)
          begin
            // whole off-time spent fast: nothing is left for slow decay
            nxt_ph[b]    = decay_ctrl_pkg::PH_OFF;
            nxt_blank[b] = decay_ctrl_pkg::DEAD_CYCLES;
            nxt_g[b]     = '0;
          end
          else if ((osc_tick && fcnt_ff[b] == 8'h01) || sel == 2'b00)
          begin
            // the slow pair waits out a dead time after the reverse pair
            nxt_ph[b]    = decay_ctrl_pkg::PH_SLOW;
            nxt_blank[b] = decay_ctrl_pkg::DEAD_CYCLES;
            nxt_g[b]     = '0;
          end
        end
        decay_ctrl_pkg::PH_SLOW:
        begin
          // both low sides recirculate; the off source never turns on
          if (!sync_rect_disable && !zero_ff[b] && blank_ff[b] == 8'h00)
            nxt_g[b] = 4'b0101;
          if (osc_tick)
          begin
            nxt_cnt[b] = cnt_ff[b] - 8'h01;
            if (cnt_ff[b] <= 8'h01)
            begin
              nxt_ph[b]    = decay_ctrl_pkg::PH_OFF;
              nxt_blank[b] = decay_ctrl_pkg::DEAD_CYCLES;
              nxt_g[b]     = '0;
            end
          end
        end
        decay_ctrl_pkg::PH_OFF:
        begin
          if (osc_tick && blank_ff[b] == 8'h01)
          begin
            nxt_ph[b]    = decay_ctrl_pkg::PH_DRIVE;
            nxt_blank[b] = decay_ctrl_pkg::BLANK_CYCLES;
          end
        end
        default: nxt_ph[b] = decay_ctrl_pkg::PH_OFF;
      endcase
      if (!gate_ok)
        nxt_g[b] = '0;
      if (home_ff)
      begin
        nxt_prev[b]  = '0;
        nxt_mixed[b] = 1'b1;
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (srst)
      begin
        ph_ff[b]    <= decay_ctrl_pkg::PH_DRIVE;
        cnt_ff[b]   <= 8'h00;
        fcnt_ff[b]  <= 8'h00;
        blank_ff[b] <= decay_ctrl_pkg::BLANK_CYCLES;
        prev_ff[b]  <= 8'h00;
        mixed_ff[b] <= 1'b1;
        zero_ff[b]  <= 1'b0;
        g_ff[b]     <= '0;
      end
      else
      begin
        ph_ff[b]    <= nxt_ph[b];
        cnt_ff[b]   <= nxt_cnt[b];
        fcnt_ff[b]  <= nxt_fcnt[b];
        blank_ff[b] <= nxt_blank[b];
        prev_ff[b]  <= nxt_prev[b];
        mixed_ff[b] <= nxt_mixed[b];
        zero_ff[b]  <= nxt_zero[b];
        g_ff[b]     <= nxt_g[b];
      end
    end

    no_fault_drive_a: assert property (@(posedge sys_clk) disable iff (srst)
      (over_temp || gate_regulator_rail_low) |=> g_ff[b] == '0) else $error("gates on during fault");
    zero_sel_slow_a: assert property (@(posedge sys_clk) disable iff (srst)
      (sel == 2'b00 && $stable(sel)) |-> ##1 ph_ff[b] != decay_ctrl_pkg::PH_FAST)
      else $error("fast with sel zero");
    sr_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      (sync_rect_disable && ph_ff[b] == decay_ctrl_pkg::PH_SLOW) |=> g_ff[b] == '0)
      else $error("rectifying while off");
    fast_to_slow_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ph_ff[b] == decay_ctrl_pkg::PH_FAST && osc_tick && fcnt_ff[b] == 8'h01 && cnt_ff[b] != 8'h01)
      |=> ph_ff[b] == decay_ctrl_pkg::PH_SLOW) else $error("fast not ended");
    fast_full_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ph_ff[b] == decay_ctrl_pkg::PH_FAST && osc_tick && cnt_ff[b] == 8'h01)
      |=> ph_ff[b] == decay_ctrl_pkg::PH_OFF && blank_ff[b] == decay_ctrl_pkg::DEAD_CYCLES)
      else $error("off-time overrun");
    trip_off_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ph_ff[b] == decay_ctrl_pkg::PH_DRIVE && bin[b].trip && blank_ff[b] == 8'h00)
      |=> ph_ff[b] == decay_ctrl_pkg::PH_DEAD && cnt_ff[b] == decay_ctrl_pkg::OFF_CYCLES)
      else $error("bad off start");
    blank_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      (ph_ff[b] == decay_ctrl_pkg::PH_OFF && $past(ph_ff[b]) != decay_ctrl_pkg::PH_OFF)
      |-> blank_ff[b] == decay_ctrl_pkg::DEAD_CYCLES) else $error("dead time wrong");
    zero_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
      (zero_ff[b] && ph_ff[b] == decay_ctrl_pkg::PH_SLOW) |=> g_ff[b] == '0) else $error("rectified past zero");
  end

  lock_off_a: assert property (@(posedge sys_clk) disable iff (srst)
    supply_lockout |=> br0_gates == '0 && br1_gates == '0) else $error("gates on in lockout");
  home_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    ($fell(supply_lockout)) |=> translator_home ##1 !translator_home) else $error("no home pulse");

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      translator_home <= 1'b0;
      fast_active     <= 2'b00;
    end
    else
    begin
      translator_home <= nxt_home;
      fast_active     <= {nxt_ph[1] == decay_ctrl_pkg::PH_FAST, nxt_ph[0] == decay_ctrl_pkg::PH_FAST};
    end
  end
  assign br0_gates = g_ff[0];
  assign br1_gates = g_ff[1];

endmodule // bridge_decay_and_fault_control
`default_nettype wire

/* rtl/decay_ctrl_pkg.sv */
/*
  shared constants and carriers for the bridge decay and fault control block.
  assumes a 100 MHz system clock and a master oscillator tick supplied as a one-cycle pulse.
*/
package decay_ctrl_pkg;
  localparam int unsigned LEVEL_W      = 8;
  localparam int unsigned CNT_W        = 8;
  // master oscillator cycle counts
  localparam logic [7:0]  OFF_CYCLES   = 8'h57;  // 87
  localparam logic [7:0]  BLANK_CYCLES = 8'h06;
  localparam logic [7:0]  DEAD_CYCLES  = 8'h03;
  // default fast portion per selector code, in oscillator cycles
  localparam logic [7:0]  FAST_SEL0    = 8'h00;
  localparam logic [7:0]  FAST_SEL1    = 8'h10;
  localparam logic [7:0]  FAST_SEL2    = 8'h2B;
  localparam logic [7:0]  FAST_SEL3    = 8'h57;

  typedef enum logic [2:0] {
    PH_DRIVE = 3'b000,
    PH_DEAD  = 3'b001,
    PH_FAST  = 3'b011,
    PH_SLOW  = 3'b010,
    PH_OFF   = 3'b110
  } phase_t;

  // gate drive of one full bridge
  typedef struct packed {
    logic high_a;
    logic low_a;
    logic high_b;
    logic low_b;
  } gates_t;

  // per-bridge inputs from translator and analog front end
  typedef struct packed {
    logic [LEVEL_W-1:0] level;
    logic               pol;
    logic               step_pulse;
    logic               trip;
    logic               zero_cur;
  } bridge_in_t;
endpackage

/* testbench/winding_model.sv */
/*
  behavioural winding and sense front end for one external full bridge.
  assumes registered gate drive on sys_clk and forward drive coded 1001.
*/
`timescale 1ns/10ps
`default_nettype none
module winding_model #(
  parameter int RISE = 30
) (
  // clock
  input  wire logic                   sys_clk,
  // bridge side
  input  wire decay_ctrl_pkg::gates_t gates,
  input  wire logic                   zc_en,
  // sense side
  output logic                        trip,
  output logic                        zero_cur
);
  int run_ff;
  int dec_ff;

  always_ff @(posedge sys_clk)
  begin
    run_ff <= (gates == 4'h9) ? run_ff + 1 : 0;
    dec_ff <= (gates != 4'h9) ? dec_ff + 1 : 0;
  end

  // current builds only under forward drive; run must outlast blanking
  assign trip     = run_ff >= RISE;
  assign zero_cur = zc_en && dec_ff >= 4;
endmodule // winding_model
`default_nettype wire

/* testbench/bridge_decay_and_fault_control_tb.sv */
/*
  self-checking bench for the bridge decay and fault control block.
  assumes one winding model per bridge closes the current loop.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_decay_and_fault_control_tb;
  logic                       sys_clk = 1'b0;
  logic                       srst = 1'b1;
  logic                       osc_tick = 1'b0;
  logic [1:0]                 sel = 2'h0;
  logic                       srd = 1'b0;
  logic [2:0]                 flt = 3'h0;
  logic [7:0]                 lvl0 = 8'h00;
  logic [7:0]                 lvl1 = 8'h00;
  logic                       stp0 = 1'b0;
  logic                       stp1 = 1'b0;
  logic                       zc_en = 1'b0;
  logic                       f1 = 1'b0;
  logic                       t0, t1, z0, z1, home;
  logic [1:0]                 fa;
  decay_ctrl_pkg::gates_t     g0, g1;
  decay_ctrl_pkg::bridge_in_t b0, b1;
  int                         fail_count = 0;
  int                         compares = 0;
  // sel, level, rect off, zero enable, fast ticks, slow gates
  logic [31:0]                rows [7] = '{32'h18000005, 32'h14000105, 32'h220002B5, 32'h31000570,
                                           32'h00800005, 32'h10810000, 32'h10401100};

  assign b0 = {lvl0, 1'b1, stp0, t0, z0};
  assign b1 = {lvl1, 1'b1, stp1, t1, z1};

  initial forever #5 sys_clk = ~sys_clk;
  // oscillator tick every second clock keeps the counts short but distinct
  always @(posedge sys_clk) osc_tick <= ~osc_tick;

  bridge_decay_and_fault_control bridge_decay_and_fault_control_i (
    .sys_clk(sys_clk), .srst(srst), .osc_tick(osc_tick),
    .fast_decay_sel_lo(sel[0]), .fast_decay_sel_hi(sel[1]), .sync_rect_disable(srd),
    .over_temp(flt[0]), .gate_regulator_rail_low(flt[1]), .supply_lockout(flt[2]),
    .br0_in(b0), .br1_in(b1), .translator_home(home),
    .br0_gates(g0), .br1_gates(g1), .fast_active(fa));

  winding_model wm0_i (.sys_clk(sys_clk), .gates(g0), .zc_en(zc_en), .trip(t0), .zero_cur(z0));
  winding_model wm1_i (.sys_clk(sys_clk), .gates(g1), .zc_en(1'b0), .trip(t1), .zero_cur(z1));

  task automatic cyc;
    @(posedge sys_clk);
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_g(input logic [3:0] pat);
    int i;
    i = 0;
    while (g0 !== pat && i < 400)
    begin
      cyc;
      #1;
      i++;
    end
    if (i == 400)
    begin
      fail_count++;
      $display("[FAIL] gate wait expected %h seen %h", pat, g0);
      wrap_up;
    end
  endtask

  initial
  begin
    int          n;
    int          fc;
    int          hc;
    logic [3:0]  so;
    logic [7:0]  acc;
    logic [7:0]  hg;
    logic [31:0] r;
    repeat (6) cyc;
    srst <= 1'b0;
    stp1 <= 1'b1;
    lvl1 <= 8'hFF;
    cyc;
    stp1 <= 1'b0;
    #1;
    chk("gates after reset", {g0, g1}, 8'h00);
    chk("flags after reset", {5'h00, home, fa}, 8'h00);
    foreach (rows[i])
    begin
      r = rows[i];
      wait_g(4'h9);
      cyc;
      sel <= r[29:28];
      srd <= r[16];
      zc_en <= r[12];
      cyc;
      stp0 <= 1'b1;
      lvl0 <= r[27:20];
      cyc;
      stp0 <= 1'b0;
      wait_g(4'h0);
      n = 0;
      fc = 0;
      so = 4'h0;
      do
      begin
        cyc;
        #1;
        n++;
        if (fa[0])
          fc++;
        else if (g0 !== 4'h9)
          so |= g0;
        f1 |= fa[1];
      end
      while (g0 !== 4'h9 && n < 400);
      if (n >= 400)
      begin
        fail_count++;
        $display("[FAIL] off-time end expected 9 seen %h", g0);
        wrap_up;
      end
      chk("fast cycles", 8'(fc), {r[10:4], 1'b0});
      chk("slow gates", {4'h0, so}, {4'h0, r[3:0]});
      chk("off window", 8'(n > 183 && n < 195), 8'h01);
    end
    chk("other bridge fast", {7'h00, f1}, 8'h00);
    for (int f = 0; f < 3; f++)
    begin
      wait_g(4'h9);
      cyc;
      flt <= 3'h1 << f;
      acc = 8'h00;
      repeat (2) cyc;
      #1;
      chk("gates in fault", {g0, g1}, 8'h00);
      repeat (20)
      begin
        cyc;
        #1;
        acc |= {g0, g1};
      end
      chk("gates held off", acc, 8'h00);
      cyc;
      flt <= 3'h0;
      hc = 0;
      hg = 8'h00;
      repeat (10)
      begin
        cyc;
        #1;
        if (home)
        begin
          hc++;
          hg = {g0, g1};
        end
      end
      chk("home pulses", 8'(hc), (f == 2) ? 8'h01 : 8'h00);
      chk("gates at home", hg, 8'h00);
    end
    wrap_up;
  end
endmodule // bridge_decay_and_fault_control_tb
`default_nettype wire
